//--- hsi_ctrl.sv
// Status flags, interrupt mask, soft reset and boost supply configuration
// reached over a two-wire serial register bus (7-bit device address).
// Assumes status inputs come from logic on clk_sys; scl and sda are pins.
`timescale 1ns/100ps

module hsi_ctrl
    import hsi_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h5a  // Arbitrary bus address
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Serial register bus pins
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // Live status sources
    input  wire logic       undervoltStatus,
    input  wire logic       bufAlmostEmptyStatus,
    input  wire logic       bufAlmostFullStatus,
    input  wire logic       overcurrentStatus,
    input  wire logic       overtempStatus,
    input  wire logic       playbackDoneStatus,
    // Interrupt and supply control
    output logic            irqOutN,
    output logic            supplyModeSelect,
    output logic [6:0]      supplyVoltageCode
);

    // Zero is the general call address and would answer every broadcast
    if (DEV_ADDR == 7'h00) begin : g_bad_addr
        $error("DEV_ADDR must not be the general call address");
    end

    // ==========================================================
    // Pin synchronisers: a level counts once stages two and three agree
    logic [2:0]  sclSync;
    logic [2:0]  sdaSync;
    logic        sclLvl;
    logic        sdaLvl;
    logic        sclPrev;
    logic        sdaPrev;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclSync <= 3'h7;
            sdaSync <= 3'h7;
        end else begin
            sclSync <= {sclSync[1:0], sclIn};
            sdaSync <= {sdaSync[1:0], sdaIn};
        end
    end

    // Filtered levels and their previous values for edge detection
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclLvl  <= 1'b1;
            sdaLvl  <= 1'b1;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            if (sclSync[1] == sclSync[2]) sclLvl <= sclSync[2];
            if (sdaSync[1] == sdaSync[2]) sdaLvl <= sdaSync[2];
            sclPrev <= sclLvl;
            sdaPrev <= sdaLvl;
        end
    end

    // ==========================================================
    // Bus events
    wire sclRise   = sclLvl & ~sclPrev;
    wire sclFall   = ~sclLvl & sclPrev;
    wire startCond = sclLvl & sclPrev & sdaPrev & ~sdaLvl;
    wire stopCond  = sclLvl & sclPrev & ~sdaPrev & sdaLvl;

    // ==========================================================
    // Register state
    hsi_state_t      state;
    logic [3:0]      bitCnt;
    logic            ackPhase;
    logic            hostAck;
    logic [7:0]      shiftReg;
    logic [7:0]      txByte;
    logic [7:0]      ptr;
    logic [SRC_W-1:0] flags;
    logic [7:0]      mask;
    logic [7:0]      boost;

    // Live status vector in register bit order
    wire [SRC_W-1:0] statusVec = {undervoltStatus,
                                  bufAlmostEmptyStatus,
                                  bufAlmostFullStatus,
                                  overcurrentStatus,
                                  overtempStatus,
                                  playbackDoneStatus};

    // Byte-level decodes of the serial engine
    wire rxState  = (state == ST_ADDR) || (state == ST_PTR)
                    || (state == ST_WDATA);
    wire byteDone = rxState && sclFall && !ackPhase
                    && (bitCnt == BYTE_BITS);
    wire ackEnd   = rxState && sclFall && ackPhase;
    wire addrMatch = (shiftReg[7:1] == DEV_ADDR);
    wire wrEvent  = byteDone && (state == ST_WDATA);
    wire loadTx   = (ackEnd && (state == ST_ADDR) && shiftReg[0])
                    || ((state == ST_RDATA) && sclFall
                        && (bitCnt == ACK_SLOT) && hostAck);
    wire readFlags = loadTx && (ptr == OFS_FLAGS);
    wire softReset = wrEvent && (ptr == OFS_SOFT_RESET)
                     && (shiftReg == CODE_SOFT_RESET);

    // Read mux; unmapped and write-only offsets read zero
    wire [7:0] readData =
        (ptr == OFS_STATUS) ? {RSVD_ZERO, statusVec} :
        (ptr == OFS_FLAGS)  ? {RSVD_ZERO, flags}     :
        (ptr == OFS_MASK)   ? mask                   :
        (ptr == OFS_BOOST)  ? boost                  : READ_ZERO;

    // Set wins over the read clear so no event is lost
    wire [SRC_W-1:0] next_flags =
        (readFlags ? {SRC_W{1'b0}} : flags) | statusVec;

    // Any latched flag whose mask bit is open asks for the interrupt
    wire irqWant = |(flags & ~mask[SRC_W-1:0]);

    // ==========================================================
    // Serial engine: stop and start override any byte in flight
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state    <= ST_IDLE;
            bitCnt   <= 4'h0;
            ackPhase <= 1'b0;
            hostAck  <= 1'b0;
            shiftReg <= 8'h00;
            txByte   <= 8'h00;
            sdaOe    <= 1'b0;
        end else if (stopCond) begin
            state    <= ST_IDLE;
            ackPhase <= 1'b0;
            sdaOe    <= 1'b0;
        end else if (startCond) begin
            state    <= ST_ADDR;
            bitCnt   <= 4'h0;
            ackPhase <= 1'b0;
            sdaOe    <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (sclRise && bitCnt < BYTE_BITS) begin
                        shiftReg <= {shiftReg[6:0], sdaLvl};
                        bitCnt   <= bitCnt + 4'h1;
                    end else if (byteDone) begin
                        ackPhase <= 1'b1;
                        sdaOe    <= (state != ST_ADDR) || addrMatch;
                        if (state == ST_ADDR && !addrMatch) begin
                            state <= ST_IDLE;  // Not ours: stay off bus
                        end
                    end else if (ackEnd) begin
                        ackPhase <= 1'b0;
                        bitCnt   <= 4'h0;
                        sdaOe    <= 1'b0;
                        if (loadTx) begin
                            state  <= ST_RDATA;
                            txByte <= readData;
                            sdaOe  <= ~readData[7];
                        end else if (state == ST_ADDR) begin
                            state <= ST_PTR;
                        end else begin
                            state <= ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise && bitCnt < ACK_SLOT) begin
                        bitCnt <= bitCnt + 4'h1;
                        if (bitCnt == BYTE_BITS) hostAck <= ~sdaLvl;
                    end else if (sclFall && bitCnt == ACK_SLOT) begin
                        bitCnt <= 4'h0;
                        if (hostAck) begin
                            txByte <= readData;
                            sdaOe  <= ~readData[7];
                        end else begin
                            state <= ST_IDLE;  // Host ended the read
                            sdaOe <= 1'b0;
                        end
                    end else if (sclFall && bitCnt == BYTE_BITS) begin
                        sdaOe <= 1'b0;  // Let the host drive its ack
                    end else if (sclFall) begin
                        txByte <= {txByte[6:0], 1'b0};
                        sdaOe  <= ~txByte[6];
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Pointer: set by the second byte, steps after each written byte and as each read byte is loaded
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ptr <= 8'h00;
        end else if (byteDone && state == ST_PTR) begin
            ptr <= shiftReg;
        end else if (wrEvent || loadTx) begin
            ptr <= ptr + 8'h01;
        end
    end

    // ==========================================================
    // Flags, mask and boost registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flags <= RST_FLAGS;
            mask  <= RST_MASK;
            boost <= RST_BOOST;
        end else begin
            flags <= next_flags;
            if (softReset) begin
                mask  <= RST_MASK;
                boost <= RST_BOOST;
            end else if (wrEvent && ptr == OFS_MASK) begin
                mask <= shiftReg;
            end else if (wrEvent && ptr == OFS_BOOST) begin
                boost <= shiftReg;
            end
        end
    end

    // Interrupt pin: low while any unmasked flag is set
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irqOutN <= 1'b1;
            sdaOut  <= 1'b0;
        end else begin
            irqOutN <= ~irqWant;
            sdaOut  <= 1'b0;  // Open drain: only ever pulls low
        end
    end

    // Supply controls come straight from the boost register
    assign supplyModeSelect  = boost[BIT_BOOST_MODE];
    assign supplyVoltageCode = boost[6:0];

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence softWrite_s;
        wrEvent && ptr == OFS_SOFT_RESET && shiftReg == CODE_SOFT_RESET;
    endsequence

    sequence flagRead_s;
        readFlags && statusVec == {SRC_W{1'b0}};
    endsequence

    soft_reset_a: assert property (softWrite_s |=>
        mask == RST_MASK && boost == RST_BOOST)
        else $error("soft reset did not restore configuration");
    status_read_a: assert property (loadTx && ptr == OFS_STATUS |=>
        txByte == {RSVD_ZERO, $past(statusVec)})
        else $error("status byte does not match live status");
    uv_latch_a: assert property (undervoltStatus |=>
        flags[BIT_UNDERVOLT])
        else $error("undervoltage flag not latched");
    empty_latch_a: assert property (bufAlmostEmptyStatus |=>
        flags[BIT_ALM_EMPTY])
        else $error("almost-empty flag not latched");
    full_latch_a: assert property (bufAlmostFullStatus |=>
        flags[BIT_ALM_FULL])
        else $error("almost-full flag not latched");
    temp_latch_a: assert property (overtempStatus |=>
        flags[BIT_OVERTEMP])
        else $error("overtemperature flag not latched");
    done_latch_a: assert property (playbackDoneStatus |=>
        flags[BIT_DONE])
        else $error("playback-done flag not latched");
    oc_latch_a: assert property (overcurrentStatus ##1 !readFlags
        |=> flags[BIT_OVERCUR])
        else $error("overcurrent flag lost");
    read_clear_a: assert property (flagRead_s |=>
        flags == {SRC_W{1'b0}})
        else $error("flags not cleared by read");
    irq_gate_a: assert property (
        irqOutN == !$past(irqWant))
        else $error("interrupt pin does not follow unmasked flags");
    boost_write_a: assert property (
        wrEvent && ptr == OFS_BOOST && !softReset |=>
        {supplyModeSelect, supplyVoltageCode} == $past(shiftReg))
        else $error("boost write not applied");
    addr_nack_a: assert property (byteDone && state == ST_ADDR
        && !addrMatch |=> !sdaOe && state == ST_IDLE [*2])
        else $error("foreign address acknowledged");

endmodule : hsi_ctrl

//--- hsi_pkg.sv
// Constants shared by the haptic status and interrupt controller.
// Assumes the single-clock serial register slave in hsi_ctrl.sv.
package hsi_pkg;

    // ==========================================================
    // Register offsets (8-bit register pointer)
    localparam logic [7:0] OFS_SOFT_RESET = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h01;
    localparam logic [7:0] OFS_FLAGS      = 8'h02;
    localparam logic [7:0] OFS_MASK       = 8'h03;
    localparam logic [7:0] OFS_BOOST      = 8'h06;

    // ==========================================================
    // Reset values and command codes
    localparam logic [5:0] RST_FLAGS       = 6'h10;
    localparam logic [7:0] RST_MASK        = 8'hff;
    localparam logic [7:0] RST_BOOST       = 8'h58;
    localparam logic [7:0] CODE_SOFT_RESET = 8'haa;
    localparam logic [1:0] RSVD_ZERO       = 2'h0;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // ==========================================================
    // Field positions
    localparam int SRC_W          = 6;
    localparam int BIT_UNDERVOLT  = 5;
    localparam int BIT_ALM_EMPTY  = 4;
    localparam int BIT_ALM_FULL   = 3;
    localparam int BIT_OVERCUR    = 2;
    localparam int BIT_OVERTEMP   = 1;
    localparam int BIT_DONE       = 0;
    localparam int BIT_BOOST_MODE = 7;

    // ==========================================================
    // Serial bus byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT  = 4'h9;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_RDATA
    } hsi_state_t;

endpackage : hsi_pkg

//--- hsi_host_model.sv
// Host processor model that masters the two-wire register bus.
// Assumes an open-drain data line with a pull-up; sdaOe high pulls it low.
`timescale 1ns/100ps
module hsi_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h5a  // Arbitrary bus address
) (
    // Clock
    input  wire logic       clk_sys,
    // Bus pins
    input  wire logic       sdaOe,
    output logic            sclOut,
    output logic            sdaLine,
    // Read results
    output logic            rdValid,
    output logic [7:0]      rdData
);
    logic hostPull;
    // Wired-and with pull-up: a released line reads high, never stale
    assign sdaLine = ~(hostPull | sdaOe);
    initial begin
        sclOut = 1'b1;
        hostPull = 1'b0;
        rdValid = 1'b0;
        rdData = 8'h00;
    end
    // ==========================================================
    // Bit level: six cycles keeps each scl phase above five
    task automatic wait_half();
        repeat (6) @(posedge clk_sys);
    endtask : wait_half
    // Data moves well after scl fell, sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        repeat (2) @(posedge clk_sys);
        hostPull <= ~b;
        wait_half();
        sclOut <= 1'b1;
        wait_half();
        @(negedge clk_sys) s = sdaLine;
        @(posedge clk_sys) sclOut <= 1'b0;
    endtask : bit_io
    // Bytes go MSB first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] b, input logic ackIn,
                           output logic [7:0] s, output logic ackOut);
        logic t;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], t);
            s[i] = t;
        end
        bit_io(ackIn, ackOut);
    endtask : byte_io
    // Also serves as repeated start from scl low
    task automatic start_cond();
        repeat (2) @(posedge clk_sys);
        hostPull <= 1'b0;
        wait_half();
        sclOut <= 1'b1;
        wait_half();
        hostPull <= 1'b1;
        wait_half();
        sclOut <= 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        repeat (2) @(posedge clk_sys);
        hostPull <= 1'b1;
        wait_half();
        sclOut <= 1'b1;
        wait_half();
        hostPull <= 1'b0;
        wait_half();
    endtask : stop_cond
    // ==========================================================
    // Transfers: probe returns the ack level, 0 means the address was taken
    task automatic probe(input logic [6:0] a, output logic ack);
        logic [7:0] d;
        start_cond();
        byte_io({a, 1'b0}, 1'b1, d, ack);
        stop_cond();
    endtask : probe
    task automatic write_reg(input logic [7:0] p, input logic [7:0] v);
        logic [7:0] d;
        logic       k;
        start_cond();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, d, k);
        byte_io(p, 1'b1, d, k);
        byte_io(v, 1'b1, d, k);
        stop_cond();
    endtask : write_reg
    // Pointer write, repeated start, one byte read, host NACK
    task automatic read_reg(input logic [7:0] p);
        logic [7:0] d;
        logic       k;
        start_cond();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, d, k);
        byte_io(p, 1'b1, d, k);
        start_cond();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, d, k);
        byte_io(8'hff, 1'b1, d, k);
        rdData <= d;
        rdValid <= 1'b1;
        @(posedge clk_sys) rdValid <= 1'b0;
        stop_cond();
    endtask : read_reg
endmodule : hsi_host_model

//--- hsi_ctrl_bench.sv
// Self-checking bench for the status, interrupt and boost register block.
// Assumes hsi_host_model.sv masters the register bus on the DUT's pins.
`timescale 1ns/100ps
module hsi_ctrl_bench import hsi_pkg::*;;
    localparam logic [6:0] BUS_ADDR = 7'h5a;  // Arbitrary bus address
    logic             clk_sys, rstn, sclOut, sdaLine, sdaOut, sdaOe;
    logic             irqOutN, supplyModeSelect, rdValid;
    logic [5:0]       statusBits;
    logic [6:0]       supplyVoltageCode;
    logic [7:0]       rdData;
    logic [7:0]       expQ[$];
    string            nameQ[$];
    int               numErrors, comparisons;
    logic [31:0]      rnd;
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    hsi_ctrl #(.DEV_ADDR(BUS_ADDR)) i_hsi_ctrl (
        .clk_sys(clk_sys), .rstn(rstn), .sclIn(sclOut), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe),
        .undervoltStatus(statusBits[5]), .bufAlmostEmptyStatus(statusBits[4]),
        .bufAlmostFullStatus(statusBits[3]),
        .overcurrentStatus(statusBits[2]), .overtempStatus(statusBits[1]),
        .playbackDoneStatus(statusBits[0]), .irqOutN(irqOutN),
        .supplyModeSelect(supplyModeSelect),
        .supplyVoltageCode(supplyVoltageCode));
    hsi_host_model #(.DEV_ADDR(BUS_ADDR)) i_hsi_host_model (
        .clk_sys(clk_sys), .sdaOe(sdaOe), .sclOut(sclOut),
        .sdaLine(sdaLine), .rdValid(rdValid), .rdData(rdData));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic check_value(input string what, input logic [7:0] e,
                               input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : check_value
    // Note the expectation first; the watcher retires it on the result
    task automatic expect_read(input string w, input logic [7:0] p,
                               input logic [7:0] e);
        expQ.push_back(e);
        nameQ.push_back(w);
        i_hsi_host_model.read_reg(p);
    endtask : expect_read
    task automatic complete_run();
        if (numErrors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // Each read result retires the oldest pending expectation
    always @(posedge clk_sys) begin
        if (rdValid === 1'b1) begin
            check_value(nameQ.pop_front(), expQ.pop_front(), rdData);
        end
    end
    // Whole run is about 34k cycles; this cuts a hang well past that
    initial begin
        repeat (90000) @(posedge clk_sys);
        numErrors++;
        complete_run();
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] pat, msk;
        logic       k;
        rstn = 1'b0;
        statusBits = 6'h00;
        numErrors = 0;
        comparisons = 0;
        rnd = 32'hfb79;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(negedge clk_sys);
        check_value("irqOutN", 8'h01, {7'h0, irqOutN});
        check_value("sdaOut", 8'h00, {7'h0, sdaOut});
        check_value("mode", 8'h00, {7'h0, supplyModeSelect});
        check_value("code", 8'h58, {1'b0, supplyVoltageCode});
        expect_read("mask", OFS_MASK, 8'hff);
        expect_read("boost", OFS_BOOST, 8'h58);
        expect_read("flags", OFS_FLAGS, 8'h10);
        expect_read("flags", OFS_FLAGS, 8'h00);
        // One-hot sources with only that mask open, then random mixes
        for (int n = 0; n < 12; n++) begin
            rnd = xs(rnd);
            pat = (n < 6) ? (8'h01 << n) : {2'b00, rnd[5:0]};
            msk = (n < 6) ? ~pat : {2'b11, rnd[13:8]};
            i_hsi_host_model.write_reg(OFS_MASK, msk);
            @(posedge clk_sys) statusBits <= pat[5:0];
            repeat (4) @(negedge clk_sys);
            k = ((pat[5:0] & ~msk[5:0]) == 6'h00);
            check_value("irqOutN", {7'h0, k}, {7'h0, irqOutN});
            expect_read("status", OFS_STATUS, pat);
            @(posedge clk_sys) statusBits <= 6'h00;
            expect_read("flags", OFS_FLAGS, pat);
            repeat (4) @(negedge clk_sys);
            check_value("irqOutN", 8'h01, {7'h0, irqOutN});
            expect_read("flags", OFS_FLAGS, 8'h00);
        end
        i_hsi_host_model.write_reg(OFS_BOOST, 8'ha8);
        @(negedge clk_sys);
        check_value("mode", 8'h01, {7'h0, supplyModeSelect});
        check_value("code", 8'h28, {1'b0, supplyVoltageCode});
        i_hsi_host_model.write_reg(OFS_SOFT_RESET, 8'h55);
        expect_read("boost", OFS_BOOST, 8'ha8);
        expect_read("unmapped", 8'h05, 8'h00);
        i_hsi_host_model.write_reg(OFS_SOFT_RESET, 8'haa);
        expect_read("boost", OFS_BOOST, 8'h58);
        expect_read("mask", OFS_MASK, 8'hff);
        check_value("code", 8'h58, {1'b0, supplyVoltageCode});
        i_hsi_host_model.probe(BUS_ADDR ^ 7'h01, k);
        check_value("foreign ack", 8'h01, {7'h0, k});
        i_hsi_host_model.probe(BUS_ADDR, k);
        check_value("own ack", 8'h00, {7'h0, k});
        repeat (10) @(posedge clk_sys);
        complete_run();
    end
endmodule : hsi_ctrl_bench
